// File: rtl/tcap_pkg.sv
// Purpose: shared constants for the type-c attach and phy gating block
// Assumes: single core clock, straps sampled continuously
// Notes: arrangement codes are one-hot
package tcap_pkg;
    localparam int TCAP_ATTACH_W = 3;
    localparam int TCAP_SYNC_STAGES = 2;
    localparam logic [2:0] TCAP_ATTACH_RST = 3'h0;
    localparam logic TCAP_LANE_RST = 1'b0;
    localparam int TCAP_LANE_A_BIT = 0;
    localparam int TCAP_LANE_B_BIT = 1;
    localparam logic [1:0] TCAP_LANES_OFF = 2'h0;
    typedef enum logic [2:0] {
        TCAP_ARR_EXT = 3'h1,
        TCAP_ARR_MODE1 = 3'h2,
        TCAP_ARR_MODE2 = 3'h4
    } tcap_arr_e;
endpackage

// File: rtl/tcap_sync.sv
// Purpose: two-stage level synchroniser for pin inputs
// Assumes: inputs are slow levels from outside the clock domain
// Notes: first stage feeds only the second
`timescale 1ns/100ps
module tcap_sync #(
    parameter int W = 1
) (
    input wire logic clk, // core clock
    input wire logic rst_b, // async reset, active low
    input wire logic [W-1:0] d, // raw pin levels
    output logic [W-1:0] q // synchronised levels
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q <= '0;
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

// File: rtl/tcap_phy_gate.sv
// Purpose: turn type-c attach and orientation pins into phy enables and clock gate
// Assumes: external port controller drives attach and orientation levels
// Notes: all pins synchronised before use; outputs registered
//
// Overview of operation
// - three arrangements: external, mode 1, mode 2
// - external mux: any attach enables phy clock
// - polarity strap sets active level of inputs
// - mode select low or open picks mode 1
// - mode 1 decodes attach bit 0 with orientation
// - internal modes enable only matching phy lane
// - mode select high uses lane a/b pins
`timescale 1ns/100ps
module tcap_phy_gate (
    input wire logic clk, // core clock, 100 MHz
    input wire logic rst_b, // async reset, active low
    input wire logic ext_mux_sel, // strap, high selects external multiplexer arrangement
    input wire logic internal_mux_mode_sel, // strap, high selects mode 2
    input wire logic attach_polarity_sel, // strap, high means inputs are active high
    input wire logic [2:0] attach_detect_in, // attach indications from port controller
    input wire logic orientation_in, // plug orientation, mode 1
    input wire logic attach_lane_a_in, // attach on lane a, mode 2
    input wire logic attach_lane_b_in, // attach on lane b, mode 2
    output logic phy_clk_en, // phy clock enable, external arrangement
    output logic [1:0] phy_lane_en, // per-lane phy enable, internal arrangements
    output logic attached, // valid attach seen
    output logic [2:0] arrangement // active arrangement, one-hot
);
    import tcap_pkg::*;

    // ==========================================================
    // input synchronisation
    logic [7:0] raw_pins;
    logic [7:0] sync_pins;
    logic ext_s, mode_s, pol_s, orient_s, lane_a_s, lane_b_s;
    logic [2:0] att_s;

    assign raw_pins = {ext_mux_sel, internal_mux_mode_sel, attach_polarity_sel,
                       attach_detect_in, orientation_in, attach_lane_a_in};

    tcap_sync #(.W(8)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d(raw_pins),
        .q(sync_pins)
    );

    logic lane_b_meta_reg, lane_b_sync_reg;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lane_b_meta_reg <= TCAP_LANE_RST;
            lane_b_sync_reg <= TCAP_LANE_RST;
        end else begin
            lane_b_meta_reg <= attach_lane_b_in;
            lane_b_sync_reg <= lane_b_meta_reg;
        end
    end

    assign ext_s = sync_pins[7];
    assign mode_s = sync_pins[6];
    assign pol_s = sync_pins[5];
    assign att_s = sync_pins[4:2];
    assign orient_s = sync_pins[1];
    assign lane_a_s = sync_pins[0];
    assign lane_b_s = lane_b_sync_reg;

    // ==========================================================
    // sync pipeline fill
    // sync stages clear to 0, which reads as asserted with active-low pins;
    // hold outputs at reset until real pin levels reach the last stage
    logic [TCAP_SYNC_STAGES-1:0] fill_reg;
    logic pins_valid;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            fill_reg <= '0;
        end else begin
            fill_reg <= {fill_reg[TCAP_SYNC_STAGES-2:0], 1'b1};
        end
    end

    assign pins_valid = fill_reg[TCAP_SYNC_STAGES-1];

    // ==========================================================
    // polarity and arrangement decode
    logic [2:0] att_n;
    logic orient_n, lane_a_n, lane_b_n;
    tcap_arr_e arr_next;

    // strap low means pins are active low, so invert
    assign att_n = pol_s ? att_s : ~att_s;
    assign orient_n = pol_s ? orient_s : ~orient_s;
    assign lane_a_n = pol_s ? lane_a_s : ~lane_a_s;
    assign lane_b_n = pol_s ? lane_b_s : ~lane_b_s;

    always_comb begin
        if (ext_s) begin
            arr_next = TCAP_ARR_EXT;
        end else if (mode_s) begin
            arr_next = TCAP_ARR_MODE2;
        end else begin
            arr_next = TCAP_ARR_MODE1;
        end
    end

    // ==========================================================
    // enable decisions
    logic clk_en_next, attached_next;
    logic [1:0] lane_next;

    always_comb begin
        clk_en_next = 1'b0;
        lane_next = TCAP_LANES_OFF;
        attached_next = 1'b0;
        case (arr_next)
            TCAP_ARR_EXT: begin
                attached_next = |att_n;
                clk_en_next = attached_next;
            end
            TCAP_ARR_MODE1: begin
                attached_next = att_n[0];
                // orientation picks the lane; other lane stays off
                lane_next[TCAP_LANE_A_BIT] = att_n[0] & ~orient_n;
                lane_next[TCAP_LANE_B_BIT] = att_n[0] & orient_n;
            end
            TCAP_ARR_MODE2: begin
                // both lanes asserted is ambiguous: favour lane a
                lane_next[TCAP_LANE_A_BIT] = lane_a_n;
                lane_next[TCAP_LANE_B_BIT] = lane_b_n & ~lane_a_n;
                attached_next = lane_a_n | lane_b_n;
            end
            default: begin
                attached_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            phy_clk_en <= 1'b0;
            phy_lane_en <= TCAP_LANES_OFF;
            attached <= 1'b0;
            arrangement <= TCAP_ATTACH_RST;
        end else if (pins_valid) begin
            phy_clk_en <= clk_en_next;
            phy_lane_en <= lane_next;
            attached <= attached_next;
            arrangement <= arr_next;
        end
    end

    // ==========================================================
    // assertions
    property p_ext_gate;
        @(posedge clk) disable iff (!rst_b)
            (arrangement == TCAP_ARR_EXT) |-> (phy_clk_en == (|$past(att_n)));
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("clock gate disagrees with attach");

    property p_lane_onehot;
        @(posedge clk) disable iff (!rst_b) phy_lane_en != 2'h3;
    endproperty
    a_lane_onehot: assert property (p_lane_onehot) else $error("both phy lanes enabled");

    property p_ext_no_lane;
        @(posedge clk) disable iff (!rst_b)
            (arrangement == TCAP_ARR_EXT) |-> (phy_lane_en == 2'h0);
    endproperty
    a_ext_no_lane: assert property (p_ext_no_lane) else $error("lane enabled with external mux");

    property p_int_no_clk;
        @(posedge clk) disable iff (!rst_b)
            (arrangement != TCAP_ARR_EXT) |-> !phy_clk_en;
    endproperty
    a_int_no_clk: assert property (p_int_no_clk) else $error("ext clock enable in internal mode");

    sequence s_mode_hi;
        (!ext_mux_sel && internal_mux_mode_sel) [*4];
    endsequence
    property p_mode2_sel;
        @(posedge clk) disable iff (!rst_b) s_mode_hi |=> (arrangement == TCAP_ARR_MODE2);
    endproperty
    a_mode2_sel: assert property (p_mode2_sel) else $error("mode 2 not selected");

    sequence s_mode_lo;
        (!ext_mux_sel && !internal_mux_mode_sel) [*4];
    endsequence
    property p_mode1_sel;
        @(posedge clk) disable iff (!rst_b) s_mode_lo |=> (arrangement == TCAP_ARR_MODE1);
    endproperty
    a_mode1_sel: assert property (p_mode1_sel) else $error("mode 1 not selected");

    property p_mode1_lane;
        @(posedge clk) disable iff (!rst_b)
            (!ext_mux_sel && !internal_mux_mode_sel && attach_polarity_sel
             && attach_detect_in[0] && !orientation_in) [*4]
            |=> (phy_lane_en == 2'h1);
    endproperty
    a_mode1_lane: assert property (p_mode1_lane) else $error("mode 1 lane a not enabled");

    property p_polarity;
        @(posedge clk) disable iff (!rst_b)
            (ext_mux_sel && !attach_polarity_sel && attach_detect_in == 3'h7) [*4]
            |=> !phy_clk_en;
    endproperty
    a_polarity: assert property (p_polarity) else $error("active-low polarity ignored");

    sequence s_att_quiet;
        (ext_mux_sel && attach_polarity_sel && attach_detect_in == 3'h0) [*4];
    endsequence
    sequence s_att_rise;
        ext_mux_sel && attach_polarity_sel && attach_detect_in != 3'h0;
    endsequence
    // a new attach must not reach the gate for two more edges
    property p_sync_delay;
        @(posedge clk) disable iff (!rst_b)
            s_att_quiet ##1 s_att_rise |=> (!phy_clk_en) [*2];
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("input used before sync");

    property p_fill_quiet;
        @(posedge clk) disable iff (!rst_b)
            !pins_valid |-> (phy_lane_en == TCAP_LANES_OFF && !attached
                             && arrangement == TCAP_ATTACH_RST);
    endproperty
    a_fill_quiet: assert property (p_fill_quiet) else $error("output moved before sync filled");
endmodule

// File: verif/tcap_port_ctl_model.sv
// Purpose: behavioural type-c port controller driving attach pins
// Assumes: bench gives logical attach, orientation and lane requests
// Notes: strapped polarity applied here, as a real controller must
`timescale 1ns/100ps
module tcap_port_ctl_model (
    input wire logic pol, // high = pins active high
    input wire logic [2:0] att, // logical attach requests
    input wire logic orient, // logical orientation
    input wire logic [1:0] lane, // logical lane b/a attach
    output logic [2:0] attach_detect_in, // attach pin levels
    output logic orientation_in, // orientation pin level
    output logic attach_lane_a_in, // lane a pin level
    output logic attach_lane_b_in // lane b pin level
);
    // =========================================
    // pin levels
    assign attach_detect_in = pol ? att : ~att;
    assign orientation_in = pol ? orient : ~orient;
    assign attach_lane_a_in = pol ? lane[0] : ~lane[0];
    assign attach_lane_b_in = pol ? lane[1] : ~lane[1];
endmodule

// File: verif/typec_attach_phy_gating_bench.sv
// Purpose: self-checking bench for the attach and phy gating block
// Assumes: inputs change at the falling edge, outputs settle in 3 edges
// Notes: four cycles between a pin change and a check leaves margin
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("Error %s expected %h seen %h", n, e, g); end end
module typec_attach_phy_gating_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ext, msel, pol, orient;
    logic [2:0] att;
    logic [1:0] lane;
    logic [2:0] attach_detect_in;
    logic orientation_in, attach_lane_a_in, attach_lane_b_in;
    logic phy_clk_en, attached;
    logic [1:0] phy_lane_en;
    logic [2:0] arrangement;
    int fail_count = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    tcap_port_ctl_model peer (.pol(pol), .att(att), .orient(orient), .lane(lane),
        .attach_detect_in(attach_detect_in), .orientation_in(orientation_in),
        .attach_lane_a_in(attach_lane_a_in), .attach_lane_b_in(attach_lane_b_in));
    tcap_phy_gate dut (.clk(clk), .rst_b(rst_b), .ext_mux_sel(ext),
        .internal_mux_mode_sel(msel), .attach_polarity_sel(pol),
        .attach_detect_in(attach_detect_in), .orientation_in(orientation_in),
        .attach_lane_a_in(attach_lane_a_in), .attach_lane_b_in(attach_lane_b_in),
        .phy_clk_en(phy_clk_en), .phy_lane_en(phy_lane_en), .attached(attached),
        .arrangement(arrangement));
    // =========================================
    // shared tasks
    task automatic apply(input logic e, m, p, input logic [2:0] a, input logic o,
        input logic [1:0] l);
        @(negedge clk);
        {ext, msel, pol, att, orient, lane} = {e, m, p, a, o, l};
        repeat (4) @(negedge clk);
    endtask
    task automatic expect_out(input logic c, input logic [1:0] ln, input logic at,
        input logic [2:0] ar);
        `CHK("phy_clk_en", c, phy_clk_en)
        `CHK("phy_lane_en", ln, phy_lane_en)
        `CHK("attached", at, attached)
        `CHK("arrangement", ar, arrangement)
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // =========================================
    // scenarios
    task automatic test_ext();
        for (int p = 0; p < 2; p++) begin
            apply(1'b1, 1'b1, p[0], 3'h0, 1'b1, 2'h3);
            expect_out(1'b0, 2'h0, 1'b0, 3'h1);
            apply(1'b1, 1'b1, p[0], 3'h4, 1'b1, 2'h3);
            expect_out(1'b1, 2'h0, 1'b1, 3'h1);
        end
        $display("test_ext done");
    endtask
    task automatic test_mode1();
        for (int p = 0; p < 2; p++) begin
            apply(1'b0, 1'b0, p[0], 3'h6, 1'b0, 2'h3);
            expect_out(1'b0, 2'h0, 1'b0, 3'h2);
            apply(1'b0, 1'b0, p[0], 3'h1, 1'b0, 2'h0);
            expect_out(1'b0, 2'h1, 1'b1, 3'h2);
            apply(1'b0, 1'b0, p[0], 3'h1, 1'b1, 2'h0);
            expect_out(1'b0, 2'h2, 1'b1, 3'h2);
        end
        $display("test_mode1 done");
    endtask
    task automatic test_mode2();
        for (int p = 0; p < 2; p++) begin
            for (int l = 0; l < 4; l++) begin
                apply(1'b0, 1'b1, p[0], 3'h7, 1'b1, l[1:0]);
                expect_out(1'b0, (l == 3) ? 2'h1 : l[1:0], l != 0, 3'h4);
            end
        end
        $display("test_mode2 done");
    endtask
    task automatic test_latency();
        apply(1'b1, 1'b0, 1'b1, 3'h0, 1'b0, 2'h0);
        {ext, msel, pol, att, orient, lane} = {1'b1, 1'b0, 1'b1, 3'h2, 1'b0, 2'h0};
        repeat (2) @(posedge clk);
        #1;
        `CHK("phy_clk_en early", 1'b0, phy_clk_en)
        @(posedge clk);
        #1;
        `CHK("phy_clk_en late", 1'b1, phy_clk_en)
        $display("test_latency done");
    endtask
    // mid-run reset with active-low pins idle: no phy may wake while sync fills
    task automatic test_reset();
        @(negedge clk);
        rst_b = 1'b0;
        {ext, msel, pol, att, orient, lane} = {1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 2'h0};
        @(negedge clk);
        expect_out(1'b0, 2'h0, 1'b0, 3'h0);
        rst_b = 1'b1;
        repeat (2) begin
            @(negedge clk);
            expect_out(1'b0, 2'h0, 1'b0, 3'h0);
        end
        @(negedge clk);
        expect_out(1'b0, 2'h0, 1'b0, 3'h2);
        $display("test_reset done");
    endtask
    initial begin
        {ext, msel, pol, att, orient, lane} = {1'b1, 1'b0, 1'b1, 3'h0, 1'b0, 2'h0};
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        test_ext();
        test_mode1();
        test_mode2();
        test_latency();
        test_reset();
        wrap_up();
    end
    // hang guard, far beyond the roughly 120 cycles the tests need
    initial begin
        #50000;
        fail_count++;
        wrap_up();
    end
endmodule
